// >>> trip_pkg.sv
// Package with the types, register map and reset values of the trip logic
package trip_pkg;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic gnd;
    logic c;
    logic b;
    logic a;
  } fault_t;

  typedef struct packed {
    logic all;
    logic c;
    logic b;
    logic a;
  } trip_t;

  typedef logic [2:0][15:0] cur3_t;

  typedef enum logic [1:0] {
    MODE_THREE_POLE = 2'h0,
    MODE_LEAD = 2'h1,
    MODE_LAG = 2'h2
  } two_phase_fault_trip_mode_t;

  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] MINTRIP_ADDR = 32'h0000_0004;
  localparam logic [31:0] POLEOPEN_ADDR = 32'h0000_0008;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_000C;
  localparam logic [31:0] TRIPCNT_ADDR = 32'h0000_0010;
  localparam logic [31:0] IACC_ADDR = 32'h0000_0020;
  localparam logic [31:0] IMAX_ADDR = 32'h0000_0030;
  localparam logic [31:0] CLOSECNT_ADDR = 32'h0000_0040;
  localparam int NUM_WORDS = 20;
  localparam int NUM_FN = 8;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TRIP_DEP_BIT = 2;
  localparam int CTRL_LOCK_CLR_BIT = 3;
  localparam int CTRL_STORE_CLR_BIT = 4;

  // ----------------------------------------
  // Reset values and fault current divider
  // ----------------------------------------
  localparam logic [15:0] MINTRIP_RST = 16'h03E8;
  localparam logic [15:0] POLEOPEN_RST = 16'h0064;
  localparam logic [15:0] FAULT_DIV = 16'h000A;

endpackage

// >>> protection_trip_logic.sv
// Central trip logic: pole selection, trip latches, lockout, alarms, counters
`timescale 1ns/10ps
`default_nettype none

module protection_trip_logic (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic RETAIN_CLR,
  input wire logic [trip_pkg::NUM_FN-1:0] PROT_TRIP_IN,
  input wire logic PROT_ACTIVE_IN,
  input wire trip_pkg::fault_t FAULT_IN,
  input wire logic SINGLE_POLE_PERMIT_IN,
  input wire logic AR_READY_1P_IN,
  input wire trip_pkg::cur3_t POLE_CURRENT,
  input wire trip_pkg::cur3_t FAULT_CURRENT,
  input wire logic LOCKOUT_SET_IN,
  input wire logic LOCKOUT_RESET_IN,
  input wire logic LOCKOUT_KEY_RESET_IN,
  input wire logic AR_CLOSE_IN,
  input wire logic AR_FIRST_CYCLE_IN,
  input wire logic AR_AFTER_1P_IN,
  output var trip_pkg::trip_t TRIP_OUT,
  output var trip_pkg::trip_t DIFF_ALARM_OUT,
  output logic GENERAL_TRIP_OUT,
  output logic LOCKOUT_OUT,
  output var trip_pkg::fault_t STORED_FAULT_OUT,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);
  import trip_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_word [NUM_WORDS];
  logic mapped;
  logic [4:0] idx;
  logic wr_en;

  assign mapped = (WB_ADR_I[31:7] == 25'h0) && (WB_ADR_I[6:2] < 5'(NUM_WORDS));
  assign idx = WB_ADR_I[6:2];
  // Writes land on the edge where ack is seen high by the master
  assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q && mapped;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        r[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic wr_at(input logic [31:0] a);
    return wr_en && (idx == a[6:2]);
  endfunction

  // Registered ack gives one wait state and drops itself the cycle after
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
      dat_q <= mapped ? rd_word[idx] : 32'h0;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  two_phase_fault_trip_mode_t mode_q;
  logic trip_dep_q;
  logic [15:0] min_trip_duration_q;
  logic [15:0] pole_open_current_threshold_q;
  logic [31:0] ctrl_wr;

  assign ctrl_wr = merge({29'h0, trip_dep_q, mode_q}, WB_DAT_I, WB_SEL_I);

  // Three-pole mode after reset; an unused mode code is stored as written and trips like it
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      mode_q <= MODE_THREE_POLE;
      trip_dep_q <= 1'b0;
    end else if (wr_at(CTRL_ADDR)) begin
      mode_q <= two_phase_fault_trip_mode_t'(ctrl_wr[CTRL_MODE_LSB +: 2]);
      trip_dep_q <= ctrl_wr[CTRL_TRIP_DEP_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      min_trip_duration_q <= MINTRIP_RST;
      pole_open_current_threshold_q <= POLEOPEN_RST;
    end else begin
      if (wr_at(MINTRIP_ADDR)) begin
        min_trip_duration_q <= 16'(merge({16'h0, min_trip_duration_q}, WB_DAT_I, WB_SEL_I));
      end
      if (wr_at(POLEOPEN_ADDR)) begin
        pole_open_current_threshold_q <=
          16'(merge({16'h0, pole_open_current_threshold_q}, WB_DAT_I, WB_SEL_I));
      end
    end
  end

  // ----------------------------------------
  // Pole selection
  // ----------------------------------------
  logic general;
  logic single_ok;
  logic [1:0] nph;
  trip_t dec;

  assign general = |PROT_TRIP_IN;
  assign single_ok = SINGLE_POLE_PERMIT_IN || AR_READY_1P_IN;
  assign nph = 2'(FAULT_IN.a) + 2'(FAULT_IN.b) + 2'(FAULT_IN.c);

  // Anything not clearly single-pole capable falls to three-pole
  always_comb begin
    dec = '0;
    if (general) begin
      if (nph == 2'h1 && single_ok) begin
        dec.a = FAULT_IN.a;
        dec.b = FAULT_IN.b;
        dec.c = FAULT_IN.c;
      end else if (nph == 2'h2 && !FAULT_IN.gnd && single_ok && mode_q == MODE_LEAD) begin
        dec.a = FAULT_IN.a && FAULT_IN.b;
        dec.b = FAULT_IN.b && FAULT_IN.c;
        dec.c = FAULT_IN.a && FAULT_IN.c;
      end else if (nph == 2'h2 && !FAULT_IN.gnd && single_ok && mode_q == MODE_LAG) begin
        dec.b = FAULT_IN.a && FAULT_IN.b;
        dec.c = FAULT_IN.b && FAULT_IN.c;
        dec.a = FAULT_IN.a && FAULT_IN.c;
      end else begin
        dec.all = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Minimum duration timer
  // ----------------------------------------
  logic gen_q;
  logic [15:0] tmr_q;

  // Restarted on every new activation so a short pickup still gives a full pulse
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      gen_q <= 1'b0;
      tmr_q <= 16'h0;
    end else begin
      gen_q <= general;
      if (general && !gen_q) begin
        tmr_q <= min_trip_duration_q;
      end else if (tmr_q != 16'h0) begin
        tmr_q <= tmr_q - 16'h1;
      end
    end
  end

  // ----------------------------------------
  // Per-pole latches, trip counts and currents
  // ----------------------------------------
  logic [2:0] lat_q;
  logic [2:0] pole_open;
  logic all_q;
  logic quiet;
  logic [31:0] tripcnt_q [4];
  logic [31:0] iacc_q [3];
  logic [31:0] imax_q [3];

  assign quiet = !general && !PROT_ACTIVE_IN && (tmr_q == 16'h0);

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pole
      logic set_p;
      logic rise;
      logic [15:0] icap;
      assign set_p = dec.all || dec[p];
      assign rise = set_p && !lat_q[p];
      assign icap = FAULT_CURRENT[p];
      // Open when below threshold plus a tenth of the fault current
      assign pole_open[p] = 17'(POLE_CURRENT[p]) <
        17'(pole_open_current_threshold_q) + 17'(FAULT_CURRENT[p] / FAULT_DIV);

      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          lat_q[p] <= 1'b0;
        end else if (set_p) begin
          lat_q[p] <= 1'b1;
        end else if (quiet && pole_open[p]) begin
          lat_q[p] <= 1'b0;
        end
      end

      // Not cleared by SRST: these model battery-backed storage
      always_ff @(posedge SYS_CLK) begin
        if (RETAIN_CLR) begin
          tripcnt_q[p] <= 32'h0;
          iacc_q[p] <= 32'h0;
          imax_q[p] <= 32'h0;
        end else begin
          if (wr_at(TRIPCNT_ADDR + 32'(4 * p))) begin
            tripcnt_q[p] <= merge(tripcnt_q[p], WB_DAT_I, WB_SEL_I);
          end else if (rise && !dec.all) begin
            tripcnt_q[p] <= tripcnt_q[p] + 32'h1;
          end
          if (wr_at(IACC_ADDR + 32'(4 * p))) begin
            iacc_q[p] <= merge(iacc_q[p], WB_DAT_I, WB_SEL_I);
          end else if (rise) begin
            iacc_q[p] <= iacc_q[p] + 32'(icap);
          end
          if (wr_at(IMAX_ADDR + 32'(4 * p))) begin
            imax_q[p] <= merge(imax_q[p], WB_DAT_I, WB_SEL_I);
          end else if (rise && 32'(icap) > imax_q[p]) begin
            imax_q[p] <= 32'(icap);
          end
        end
      end
    end
  endgenerate

  // Three-pole flag drops once every pole has been released
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      all_q <= 1'b0;
    end else if (dec.all) begin
      all_q <= 1'b1;
    end else if (lat_q == 3'h0) begin
      all_q <= 1'b0;
    end
  end

  // Three-pole trip count, on the first cycle of a three-pole decision
  always_ff @(posedge SYS_CLK) begin
    if (RETAIN_CLR) begin
      tripcnt_q[3] <= 32'h0;
    end else if (wr_at(TRIPCNT_ADDR + 32'hC)) begin
      tripcnt_q[3] <= merge(tripcnt_q[3], WB_DAT_I, WB_SEL_I);
    end else if (dec.all && !all_q) begin
      tripcnt_q[3] <= tripcnt_q[3] + 32'h1;
    end
  end

  // ----------------------------------------
  // Outputs and group alarms
  // ----------------------------------------
  logic [1:0] nlat;

  assign nlat = 2'(lat_q[0]) + 2'(lat_q[1]) + 2'(lat_q[2]);

  // A group of latched poles reports as three-pole, so one alarm at most
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      TRIP_OUT <= '0;
      DIFF_ALARM_OUT <= '0;
      GENERAL_TRIP_OUT <= 1'b0;
    end else begin
      TRIP_OUT <= '{all: all_q, c: lat_q[2], b: lat_q[1], a: lat_q[0]};
      GENERAL_TRIP_OUT <= general;
      DIFF_ALARM_OUT <= '0;
      if (all_q || nlat > 2'h1) begin
        DIFF_ALARM_OUT.all <= 1'b1;
      end else begin
        DIFF_ALARM_OUT.a <= lat_q[0];
        DIFF_ALARM_OUT.b <= lat_q[1];
        DIFF_ALARM_OUT.c <= lat_q[2];
      end
    end
  end

  // ----------------------------------------
  // Reclosure lockout
  // ----------------------------------------
  logic lock_clr;

  assign lock_clr = LOCKOUT_RESET_IN || LOCKOUT_KEY_RESET_IN
                    || (wr_at(CTRL_ADDR) && ctrl_wr[CTRL_LOCK_CLR_BIT]);

  // Retained across SRST; set wins so a fresh cause is never lost
  always_ff @(posedge SYS_CLK) begin
    if (RETAIN_CLR) begin
      LOCKOUT_OUT <= 1'b0;
    end else if (LOCKOUT_SET_IN) begin
      LOCKOUT_OUT <= 1'b1;
    end else if (lock_clr) begin
      LOCKOUT_OUT <= 1'b0;
    end
  end

  // ----------------------------------------
  // Fault alarm storage
  // ----------------------------------------
  fault_t pend_q;
  logic tripped_q;
  logic act_q;

  // Collect during pickup; commit at dropout unless a trip was required and absent
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pend_q <= '0;
      tripped_q <= 1'b0;
      act_q <= 1'b0;
      STORED_FAULT_OUT <= '0;
    end else begin
      act_q <= PROT_ACTIVE_IN;
      if (PROT_ACTIVE_IN) begin
        pend_q <= pend_q | FAULT_IN;
        tripped_q <= tripped_q || general;
      end else begin
        pend_q <= '0;
        tripped_q <= 1'b0;
      end
      if (act_q && !PROT_ACTIVE_IN && (!trip_dep_q || tripped_q)) begin
        STORED_FAULT_OUT <= pend_q;
      end else if (wr_at(CTRL_ADDR) && ctrl_wr[CTRL_STORE_CLR_BIT]) begin
        STORED_FAULT_OUT <= '0;
      end
    end
  end

  // ----------------------------------------
  // Auto-close counters
  // ----------------------------------------
  logic [31:0] closecnt_q [4];
  logic [1:0] cidx;

  assign cidx = {!AR_AFTER_1P_IN, !AR_FIRST_CYCLE_IN};

  generate
    for (p = 0; p < 4; p++) begin : g_close
      always_ff @(posedge SYS_CLK) begin
        if (RETAIN_CLR) begin
          closecnt_q[p] <= 32'h0;
        end else if (wr_at(CLOSECNT_ADDR + 32'(4 * p))) begin
          closecnt_q[p] <= merge(closecnt_q[p], WB_DAT_I, WB_SEL_I);
        end else if (AR_CLOSE_IN && cidx == 2'(p)) begin
          closecnt_q[p] <= closecnt_q[p] + 32'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read map
  // ----------------------------------------
  always_comb begin
    rd_word[0] = {29'h0, trip_dep_q, mode_q};
    rd_word[1] = {16'h0, min_trip_duration_q};
    rd_word[2] = {16'h0, pole_open_current_threshold_q};
    rd_word[3] = {21'h0, tmr_q != 16'h0, STORED_FAULT_OUT, LOCKOUT_OUT, general,
                  all_q, lat_q};
    for (int k = 0; k < 4; k++) begin
      rd_word[4 + k] = tripcnt_q[k];
      rd_word[16 + k] = closecnt_q[k];
    end
    for (int k = 0; k < 3; k++) begin
      rd_word[8 + k] = iacc_q[k];
      rd_word[12 + k] = imax_q[k];
    end
    rd_word[11] = 32'h0;
    rd_word[15] = 32'h0;
  end

endmodule // protection_trip_logic

`default_nettype wire

// >>> breaker_model.sv
// Breaker model standing on the far side of the trip logic
`timescale 1ns/10ps
`default_nettype none

module breaker_model (
  input wire logic clk,
  input wire trip_pkg::trip_t trip,
  input wire logic stall,
  input wire logic close,
  input wire logic lockout,
  output var trip_pkg::cur3_t cur
);
  import trip_pkg::*;
  logic [2:0] open_q;

  // Poles open on command; a stalled mechanism keeps the current flowing
  always_ff @(posedge clk) begin
    for (int p = 0; p < 3; p++) begin
      if (close && !lockout)
        open_q[p] <= 1'b0;
      else if ((trip[p] || trip.all) && !stall)
        open_q[p] <= 1'b1;
    end
  end

  // An open pole carries no load current
  always_comb begin
    for (int p = 0; p < 3; p++) cur[p] = open_q[p] ? 16'h0000 : 16'h0200;
  end
endmodule // breaker_model

`default_nettype wire

// >>> trip_logic_properties.sv
// Checker with the port-level properties of the central trip logic
`timescale 1ns/10ps
`default_nettype none

module trip_logic_properties (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic RETAIN_CLR,
  input wire logic [trip_pkg::NUM_FN-1:0] PROT_TRIP_IN,
  input wire logic PROT_ACTIVE_IN,
  input wire trip_pkg::fault_t FAULT_IN,
  input wire logic SINGLE_POLE_PERMIT_IN,
  input wire logic AR_READY_1P_IN,
  input wire logic LOCKOUT_SET_IN,
  input wire logic LOCKOUT_RESET_IN,
  input wire logic LOCKOUT_KEY_RESET_IN,
  input wire trip_pkg::trip_t TRIP_OUT,
  input wire trip_pkg::trip_t DIFF_ALARM_OUT,
  input wire logic GENERAL_TRIP_OUT,
  input wire logic LOCKOUT_OUT
);
  import trip_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  // A trip starting from idle; output timing needs a clean start to be exact
  sequence s_fresh(f);
    $rose(|PROT_TRIP_IN) && TRIP_OUT == 4'h0 && FAULT_IN == f;
  endsequence

  a_one_alarm: assert property ($onehot0(DIFF_ALARM_OUT))
    else $error("two trip alarms at once");
  a_single_pole: assert property (s_fresh(4'h9) && (SINGLE_POLE_PERMIT_IN || AR_READY_1P_IN)
    |-> ##2 DIFF_ALARM_OUT == 4'h1) else $error("grounded phase a fault not single-pole");
  a_ground_three: assert property (s_fresh(4'h8) |-> ##2 DIFF_ALARM_OUT == 4'h8)
    else $error("ground fault not three-pole");
  a_general_or: assert property (!$past(SRST) |-> GENERAL_TRIP_OUT == (|$past(PROT_TRIP_IN)))
    else $error("general trip differs from the trip inputs");
  a_min_hold: assert property ($rose(TRIP_OUT.a) |=> TRIP_OUT.a [*3])
    else $error("trip dropped before minimum duration");
  a_release_idle: assert property ($fell(|TRIP_OUT) && !$past(SRST) && !$past(SRST, 2)
    |-> !$past(PROT_ACTIVE_IN, 2) && $past(PROT_TRIP_IN, 2) == '0)
    else $error("trip released while a function was active");
  a_lock_set: assert property (LOCKOUT_SET_IN && !RETAIN_CLR |=> LOCKOUT_OUT)
    else $error("lockout not set");
  a_lock_clear: assert property ((LOCKOUT_RESET_IN || LOCKOUT_KEY_RESET_IN)
    && !LOCKOUT_SET_IN |=> !LOCKOUT_OUT) else $error("lockout not cleared");
endmodule // trip_logic_properties

bind protection_trip_logic trip_logic_properties props (.SYS_CLK, .SRST, .RETAIN_CLR,
  .PROT_TRIP_IN, .PROT_ACTIVE_IN, .FAULT_IN, .SINGLE_POLE_PERMIT_IN, .AR_READY_1P_IN,
  .LOCKOUT_SET_IN, .LOCKOUT_RESET_IN, .LOCKOUT_KEY_RESET_IN, .TRIP_OUT, .DIFF_ALARM_OUT,
  .GENERAL_TRIP_OUT, .LOCKOUT_OUT);

`default_nettype wire

// >>> protection_trip_logic_tb.sv
// Self-checking testbench for the central trip logic
`timescale 1ns/10ps
`default_nettype none

module protection_trip_logic_tb;
  import trip_pkg::*;
  // ----------------------------------------
  // Stimulus, checks and scenarios
  // ----------------------------------------
  localparam logic [15:0] min_ticks = 16'h0006;
  logic clk, srst, rclr, act, perm, rdy, lset, lrst, lkey, arc, arf, ar1;
  logic gen, lock, cyc, stb, we, ack, bstall, bclose;
  logic [NUM_FN-1:0] ptrip;
  logic [31:0] adr, wdat, rdat, q;
  fault_t flt, stored;
  cur3_t pcur;
  trip_t trip, alarm;
  int num_errors, samples_checked, acc_a;
  int cnt[4];
  logic [3:0] flist [15] = '{4'h1, 4'h2, 4'h4, 4'h9, 4'hA, 4'hC, 4'h3, 4'h6, 4'h5, 4'hB,
    4'hD, 4'hE, 4'h7, 4'hF, 4'h8};

  protection_trip_logic uut (.SYS_CLK(clk), .SRST(srst), .RETAIN_CLR(rclr),
    .PROT_TRIP_IN(ptrip), .PROT_ACTIVE_IN(act), .FAULT_IN(flt), .SINGLE_POLE_PERMIT_IN(perm),
    .AR_READY_1P_IN(rdy), .POLE_CURRENT(pcur), .FAULT_CURRENT({3{16'h0100}}),
    .LOCKOUT_SET_IN(lset), .LOCKOUT_RESET_IN(lrst), .LOCKOUT_KEY_RESET_IN(lkey),
    .AR_CLOSE_IN(arc), .AR_FIRST_CYCLE_IN(arf), .AR_AFTER_1P_IN(ar1), .TRIP_OUT(trip),
    .DIFF_ALARM_OUT(alarm), .GENERAL_TRIP_OUT(gen), .LOCKOUT_OUT(lock),
    .STORED_FAULT_OUT(stored), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));

  // Breaker poles answer the latched commands
  breaker_model brk (.clk(clk), .trip(trip), .stall(bstall), .close(bclose),
    .lockout(lock), .cur(pcur));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  task automatic results;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    // A bus that never answers counts as a mismatch
    if (ack !== 1'b1) begin
      $display("unexpected wb ack expected 1 seen %b", ack);
      num_errors++;
    end
    {cyc, stb} <= 2'h0;
  endtask

  // One-cycle pulse on a lockout or close input
  task automatic pulse(input int k);
    case (k)
      0: lset <= 1'b1;
      1: lrst <= 1'b1;
      2: lkey <= 1'b1;
      default: arc <= 1'b1;
    endcase
    @(posedge clk);
    {lset, lrst, lkey, arc} <= 4'h0;
    @(posedge clk);
  endtask

  // Alarm expected for a fault, mode and single-pole permission
  function automatic trip_t exp_alarm(input logic [1:0] m, input logic [3:0] f, input logic sp);
    logic [2:0] ld;
    ld = f[2:0] & ~{f[1:0], f[2]};
    if (!sp) return 4'h8;
    if ($onehot(f[2:0])) return {1'b0, f[2:0]};
    if (!f[3] && $countones(f[2:0]) == 2 && m == 2'h1) return {1'b0, ld};
    if (!f[3] && $countones(f[2:0]) == 2 && m == 2'h2) return {1'b0, ld[1:0], ld[2]};
    return 4'h8;
  endfunction

  // A fault from idle: alarm, general trip, hold time and pole-open release
  task automatic trip_run(input logic [1:0] m, input logic [3:0] f, input logic p,
      input logic r, input int fn, input logic s);
    trip_t e;
    int n;
    e = exp_alarm(m, f, p | r);
    wb(1'b1, CTRL_ADDR, {30'h0, m});
    @(posedge clk);
    {flt, perm, rdy, bstall, act} <= {f, p, r, s, 1'b1};
    ptrip <= NUM_FN'(1) << fn;
    repeat (3) @(posedge clk);
    chk("alarm", 32'(e), 32'(alarm));
    chk("general", 32'h1, 32'(gen));
    {ptrip, act} <= '0;
    repeat (s ? 3 * min_ticks : 0) @(posedge clk);
    chk("pole closed hold", 32'h1, 32'(!s || trip !== 4'h0));
    bstall <= 1'b0;
    n = 1;
    while (trip !== 4'h0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("hold time", 32'h1, 32'(s || n > min_ticks));
    bclose <= 1'b1;
    @(posedge clk);
    bclose <= 1'b0;
    cnt[e.all ? 3 : e.c ? 2 : e.b ? 1 : 0]++;
    acc_a += int'(e.a | e.all);
  endtask

  task automatic lockout_scn;
    pulse(0);
    chk("lockout set", 32'h1, 32'(lock));
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("lockout kept", 32'h1, 32'(lock));
    for (int k = 1; k < 4; k++) begin
      pulse(0);
      if (k < 3) pulse(k);
      else wb(1'b1, CTRL_ADDR, 32'h8);
      repeat (2) @(posedge clk);
      chk("lockout clear", 32'h0, 32'(lock));
    end
  endtask

  task automatic store_scn(input logic [31:0] ctl, input logic [3:0] e);
    wb(1'b1, CTRL_ADDR, ctl);
    @(posedge clk);
    {flt, act} <= {4'h2, 1'b1};
    repeat (3) @(posedge clk);
    act <= 1'b0;
    repeat (3) @(posedge clk);
    chk("stored fault", 32'(e), 32'(stored));
  endtask

  initial begin
    {srst, rclr, bclose} = 3'h7;
    {act, perm, rdy, lset, lrst, lkey, arc, arf, ar1, cyc, stb, we, bstall} = '0;
    {ptrip, flt, adr, wdat} = '0;
    {num_errors, samples_checked, acc_a} = '0;
    cnt = '{default: 0};
    repeat (8) @(posedge clk);
    {srst, rclr, bclose} <= 3'h0;
    wb(1'b0, MINTRIP_ADDR, '0);
    chk("min ticks", 32'h3E8, q);
    wb(1'b0, CTRL_ADDR, '0);
    chk("mode", 32'h0, q);
    wb(1'b0, 32'h0000_0100, '0);
    chk("unmapped", 32'h0, q);
    lockout_scn();
    wb(1'b1, MINTRIP_ADDR, {16'h0, min_ticks});
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 15; i++) trip_run(2'(m), flist[i], i[0], m != 0, i % 8, 1'b0);
    end
    trip_run(2'h0, 4'h1, 1'b1, 1'b0, 0, 1'b1);
    for (int p = 0; p < 4; p++) begin
      wb(1'b0, TRIPCNT_ADDR + 32'(4 * p), '0);
      chk("trip count", 32'(cnt[p]), q);
    end
    wb(1'b0, IACC_ADDR, '0);
    chk("current sum", 32'(acc_a * 256), q);
    wb(1'b0, IMAX_ADDR, '0);
    chk("current max", 32'h100, q);
    wb(1'b1, TRIPCNT_ADDR, 32'h55);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    wb(1'b0, TRIPCNT_ADDR, '0);
    chk("preset kept", 32'h55, q);
    store_scn(32'h14, 4'h0);
    store_scn(32'h10, 4'h2);
    for (int i = 0; i < 4; i++) begin
      {ar1, arf} <= {~i[1], ~i[0]};
      repeat (i + 1) pulse(3);
      wb(1'b0, CLOSECNT_ADDR + 32'(4 * i), '0);
      chk("close count", 32'(i + 1), q);
    end
    results();
  end
endmodule // protection_trip_logic_tb

`default_nettype wire
